// ==== rtl/fsp_pkg.sv ====
// Shared constants for the framed serial port core.
package fsp_pkg;
    // Synchronised pin indices.
    localparam int PIN_RXC = 0;
    localparam int PIN_RXFS = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_TXC = 3;
    localparam int PIN_TXFS = 4;
    localparam int PIN_N = 5;
    // Field widths.
    localparam int DLY_W = 2;
    localparam int WLEN_W = 6;
    localparam int ECNT_W = 7;
    localparam int FBITS_W = 13;
    // Reset values of status flags.
    localparam logic RX_READY_RST = 1'b0;
    localparam logic TX_READY_RST = 1'b1;
    localparam logic ERR_RST = 1'b0;
    // Data delay codes for no delay and for one bit of delay.
    localparam logic [DLY_W-1:0] DLY_ZERO = 2'h0;
    localparam logic [DLY_W-1:0] DLY_ONE = 2'h1;
    // Bit clock period used by the bench, in nanoseconds.
    localparam int BIT_CLK_NS = 200;
endpackage

// ==== rtl/fsp_core.sv ====
// Receive and transmit datapaths of a framed synchronous serial port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Receive sync is detected on the first falling bit clock after going active.
// - Receive bits shift in after the programmed receive data delay.
// - Finished element moves to buffer on rising edge only if buffer empty.
// - Buffer to data register copy sets receive ready on next falling edge.
// - Reading the receive data register clears receive ready.
// - Transmit bits drive out after the programmed transmit data delay.
// - Data to shift register copy sets transmit ready on next falling edge.
// - Writing the transmit data register clears transmit ready.
// - Syncs one frame apart give back to back bits with no idle clocks.
// - With one bit delay, sync overlaps the last bit without disruption.
// - With zero transmit delay, the first bit leaves unaligned to the clock.
// - Per direction ignore control: 0 acts on all syncs, 1 skips unexpected.
// - A sync is unexpected when it comes a bit or more before the delay.
// - Receive unexpected sync not ignored drops element, flags error, restarts.
// - Receive unexpected sync ignored leaves current reception untouched.
// - Transmit unexpected sync not ignored aborts, flags error, resends element.
// - Transmit unexpected sync ignored lets the current element finish.
// - Ignoring syncs packs short max-rate frames into long elements.
// - Elements per phase span 1 to 128 from field values 0 to 7Fh.
// - Only the inactive to active sync transition counts.
// - Receive sync error stays until cleared; a software set also raises it.
module fsp_core #(
    parameter int DW = 32
) (
    // Clock, reset and freeze
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Receive pins
    input wire logic rx_bit_clock,
    input wire logic rx_frame_sync,
    input wire logic serial_data_in,
    // Transmit pins
    input wire logic tx_bit_clock,
    input wire logic tx_frame_sync,
    output logic serial_data_out,
    output logic serial_data_out_en,
    // Receive configuration
    input wire logic [fsp_pkg::DLY_W-1:0] rx_data_delay,
    input wire logic rx_sync_ignore,
    input wire logic [fsp_pkg::WLEN_W-1:0] rx_word_len,
    input wire logic [fsp_pkg::ECNT_W-1:0] rx_phase1_element_count,
    // Transmit configuration
    input wire logic [fsp_pkg::DLY_W-1:0] tx_data_delay,
    input wire logic tx_sync_ignore,
    input wire logic [fsp_pkg::WLEN_W-1:0] tx_word_len,
    input wire logic [fsp_pkg::ECNT_W-1:0] tx_phase1_element_count,
    // Receive processor side
    input wire logic rx_read,
    output logic [DW-1:0] rx_data_reg,
    output logic rx_ready_flag,
    output logic rx_sync_error,
    input wire logic rx_error_set,
    input wire logic rx_error_clear,
    // Transmit processor side
    input wire logic tx_write,
    input wire logic [DW-1:0] tx_write_data,
    output logic tx_ready_flag,
    output logic tx_sync_error,
    input wire logic tx_error_set,
    input wire logic tx_error_clear
);
    localparam int FB = fsp_pkg::FBITS_W;
    localparam int WL = fsp_pkg::WLEN_W;
    localparam int IW = $clog2(DW);

    // Pin synchronisers; a level is accepted once stages two and three agree.
    logic [fsp_pkg::PIN_N-1:0] pin_raw;
    logic [fsp_pkg::PIN_N-1:0] s1_r;
    logic [fsp_pkg::PIN_N-1:0] s2_r;
    logic [fsp_pkg::PIN_N-1:0] s3_r;
    logic [fsp_pkg::PIN_N-1:0] flt_r;
    logic [fsp_pkg::PIN_N-1:0] lvl;

    assign pin_raw = {tx_frame_sync, tx_bit_clock, serial_data_in,
                      rx_frame_sync, rx_bit_clock};

    genvar g;
    generate
        for (g = 0; g < fsp_pkg::PIN_N; g++) begin : g_sync
            assign lvl[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : flt_r[g];
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    flt_r[g] <= 1'b0;
                end else if (clk_en) begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    flt_r[g] <= lvl[g];
                end
            end
        end
    endgenerate

    // Receive state.
    logic rx_fs_prev_r;
    logic [FB-1:0] rx_left_r;
    logic [WL-1:0] rx_ebits_r;
    logic rx_pend_r;
    logic [fsp_pkg::DLY_W-1:0] rx_pend_cnt_r;
    logic [DW-1:0] rx_shift_reg_r;
    logic rx_done_r;
    logic [DW-1:0] rx_buffer_reg_r;
    logic rx_buf_full_r;
    logic [DW-1:0] rx_data_reg_r;
    logic rx_ready_r;
    logic rx_rdy_pend_r;
    logic rx_err_r;

    logic rx_fall, rx_rise, rx_fs, rx_din, rx_sync, rx_unexp, rx_take;
    logic rx_abort, rx_start, rx_run, rx_shift, rx_new_elem, rx_to_data;
    logic [FB-1:0] rx_fbits, rx_left_base;
    logic [WL-1:0] rx_eb_base;

    assign rx_fall = clk_en & flt_r[fsp_pkg::PIN_RXC] & ~lvl[fsp_pkg::PIN_RXC];
    assign rx_rise = clk_en & ~flt_r[fsp_pkg::PIN_RXC] & lvl[fsp_pkg::PIN_RXC];
    assign rx_fs = lvl[fsp_pkg::PIN_RXFS];
    assign rx_din = lvl[fsp_pkg::PIN_DIN];
    assign rx_sync = rx_fall & rx_fs & ~rx_fs_prev_r;
    assign rx_fbits = FB'(rx_word_len) *
                      (FB'(rx_phase1_element_count) + FB'(1));
    // Bits still to arrive, counting the one sampled now, exceed the delay.
    assign rx_unexp = rx_sync & (rx_left_r > FB'(rx_data_delay));
    assign rx_take = rx_sync & ~(rx_unexp & rx_sync_ignore);
    assign rx_abort = rx_take & rx_unexp;
    assign rx_start = rx_fall &
        ((rx_take & (rx_data_delay == fsp_pkg::DLY_ZERO)) |
         (~rx_take & rx_pend_r & (rx_pend_cnt_r == fsp_pkg::DLY_ZERO)));
    assign rx_run = rx_fall & ~rx_abort & (rx_left_r != '0);
    assign rx_shift = rx_start | rx_run;
    assign rx_new_elem = rx_start | (rx_ebits_r == '0);
    // Element length is independent of sync spacing, so ignored syncs pack.
    assign rx_eb_base = rx_new_elem ? rx_word_len : rx_ebits_r;
    assign rx_left_base = rx_start ? rx_fbits : rx_left_r;
    assign rx_to_data = rx_buf_full_r & ~rx_ready_r & ~rx_rdy_pend_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_fs_prev_r <= 1'b0;
        end else if (rx_fall) begin
            rx_fs_prev_r <= rx_fs;
        end
    end

    // Shifting; elements sit right justified with zeros above.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_shift_reg_r <= '0;
            rx_left_r <= '0;
            rx_ebits_r <= '0;
        end else if (rx_shift) begin
            if (rx_new_elem) begin
                rx_shift_reg_r <= {{(DW-1){1'b0}}, rx_din};
            end else begin
                rx_shift_reg_r <= {rx_shift_reg_r[DW-2:0], rx_din};
            end
            rx_left_r <= rx_left_base - FB'(1);
            rx_ebits_r <= rx_eb_base - WL'(1);
        end else if (rx_abort) begin
            rx_left_r <= '0;
            rx_ebits_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_pend_r <= 1'b0;
            rx_pend_cnt_r <= '0;
        end else if (rx_fall) begin
            if (rx_take && rx_data_delay != fsp_pkg::DLY_ZERO) begin
                rx_pend_r <= 1'b1;
                rx_pend_cnt_r <= rx_data_delay - fsp_pkg::DLY_ONE;
            end else if (rx_take || rx_pend_cnt_r == fsp_pkg::DLY_ZERO) begin
                rx_pend_r <= 1'b0;
            end else if (rx_pend_r) begin
                rx_pend_cnt_r <= rx_pend_cnt_r - fsp_pkg::DLY_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_done_r <= 1'b0;
        end else if (rx_shift && rx_eb_base == WL'(1)) begin
            rx_done_r <= 1'b1;
        end else if (rx_rise) begin
            rx_done_r <= 1'b0;
        end
    end

    // A finished element meeting a full buffer is lost, as in an overrun.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_buffer_reg_r <= '0;
            rx_buf_full_r <= 1'b0;
            rx_data_reg_r <= '0;
        end else if (rx_rise && rx_done_r && !rx_buf_full_r) begin
            rx_buffer_reg_r <= rx_shift_reg_r;
            rx_buf_full_r <= 1'b1;
        end else if (clk_en && rx_to_data) begin
            rx_data_reg_r <= rx_buffer_reg_r;
            rx_buf_full_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_ready_r <= fsp_pkg::RX_READY_RST;
            rx_rdy_pend_r <= 1'b0;
        end else begin
            if (rx_fall && rx_rdy_pend_r) begin
                rx_ready_r <= 1'b1;
            end else if (clk_en && rx_read) begin
                rx_ready_r <= 1'b0;
            end
            if (clk_en && rx_to_data) begin
                rx_rdy_pend_r <= 1'b1;
            end else if (rx_fall) begin
                rx_rdy_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_err_r <= fsp_pkg::ERR_RST;
        end else if (clk_en) begin
            rx_err_r <= rx_abort | rx_error_set |
                        (rx_err_r & ~rx_error_clear);
        end
    end

    // Transmit state.
    logic tx_fs_prev_r;
    logic [FB-1:0] tx_left_r;
    logic [WL-1:0] tx_ebits_r;
    logic tx_pend_r;
    logic [fsp_pkg::DLY_W-1:0] tx_pend_cnt_r;
    logic [DW-1:0] tx_shift_reg_r;
    logic [DW-1:0] tx_data_reg_r;
    logic tx_ready_r;
    logic tx_rdy_pend_r;
    logic tx_err_r;
    logic tx_restart_r;
    logic dout_r;
    logic dout_en_r;

    logic tx_fall, tx_rise, tx_sync, tx_unexp, tx_take, tx_abort;
    logic tx_start, tx_run, tx_drive, tx_new_elem, tx_use_old, tx_copy, tx_bit;
    logic [fsp_pkg::DLY_W-1:0] tx_slack;
    logic [FB-1:0] tx_fbits, tx_left_base;
    logic [WL-1:0] tx_eb_base, tx_eb_m1;
    logic [DW-1:0] tx_word;

    assign tx_fall = clk_en & flt_r[fsp_pkg::PIN_TXC] & ~lvl[fsp_pkg::PIN_TXC];
    assign tx_rise = clk_en & ~flt_r[fsp_pkg::PIN_TXC] & lvl[fsp_pkg::PIN_TXC];
    assign tx_sync = tx_fall & lvl[fsp_pkg::PIN_TXFS] & ~tx_fs_prev_r;
    assign tx_fbits = FB'(tx_word_len) *
                      (FB'(tx_phase1_element_count) + FB'(1));
    // The bit on the line is already counted off, hence one less of slack.
    assign tx_slack = (tx_data_delay == fsp_pkg::DLY_ZERO) ? fsp_pkg::DLY_ZERO :
                      tx_data_delay - fsp_pkg::DLY_ONE;
    assign tx_unexp = tx_sync & (tx_left_r > FB'(tx_slack));
    assign tx_take = tx_sync & ~(tx_unexp & tx_sync_ignore);
    assign tx_abort = tx_take & tx_unexp;
    // Zero delay launches on the sync's falling edge, not a rising one.
    assign tx_start =
        (tx_fall & tx_take & (tx_data_delay == fsp_pkg::DLY_ZERO)) |
        (tx_rise & tx_pend_r & (tx_pend_cnt_r == fsp_pkg::DLY_ZERO));
    assign tx_run = tx_rise & (tx_left_r != '0);
    assign tx_drive = tx_start | tx_run;
    assign tx_new_elem = tx_start | (tx_ebits_r == '0);
    assign tx_use_old = tx_start & (tx_restart_r | tx_abort);
    assign tx_copy = tx_drive & tx_new_elem & ~tx_use_old;
    assign tx_word = tx_copy ? tx_data_reg_r : tx_shift_reg_r;
    assign tx_eb_base = tx_new_elem ? tx_word_len : tx_ebits_r;
    assign tx_eb_m1 = tx_eb_base - WL'(1);
    assign tx_bit = tx_word[tx_eb_m1[IW-1:0]];
    assign tx_left_base = tx_start ? tx_fbits : tx_left_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_fs_prev_r <= 1'b0;
        end else if (tx_fall) begin
            tx_fs_prev_r <= lvl[fsp_pkg::PIN_TXFS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_left_r <= '0;
            tx_ebits_r <= '0;
        end else if (tx_drive) begin
            tx_left_r <= tx_left_base - FB'(1);
            tx_ebits_r <= tx_eb_m1;
        end else if (tx_abort) begin
            tx_left_r <= '0;
            tx_ebits_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_pend_r <= 1'b0;
            tx_pend_cnt_r <= '0;
        end else if (tx_take) begin
            tx_pend_r <= (tx_data_delay != fsp_pkg::DLY_ZERO);
            tx_pend_cnt_r <= tx_slack;
        end else if (tx_rise && tx_pend_r) begin
            if (tx_pend_cnt_r == fsp_pkg::DLY_ZERO) begin
                tx_pend_r <= 1'b0;
            end else begin
                tx_pend_cnt_r <= tx_pend_cnt_r - fsp_pkg::DLY_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_restart_r <= 1'b0;
        end else if (tx_start) begin
            tx_restart_r <= 1'b0;
        end else if (tx_abort) begin
            tx_restart_r <= 1'b1;
        end
    end

    // Without a fresh write the old word goes out again on the next frame.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_shift_reg_r <= '0;
        end else if (tx_copy) begin
            tx_shift_reg_r <= tx_data_reg_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_data_reg_r <= '0;
        end else if (clk_en && tx_write) begin
            tx_data_reg_r <= tx_write_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_ready_r <= fsp_pkg::TX_READY_RST;
            tx_rdy_pend_r <= 1'b0;
        end else begin
            if (tx_fall && tx_rdy_pend_r) begin
                tx_ready_r <= 1'b1;
            end else if (clk_en && tx_write) begin
                tx_ready_r <= 1'b0;
            end
            if (tx_copy) begin
                tx_rdy_pend_r <= 1'b1;
            end else if (tx_fall) begin
                tx_rdy_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_err_r <= fsp_pkg::ERR_RST;
        end else if (clk_en) begin
            tx_err_r <= tx_abort | tx_error_set | (tx_err_r & ~tx_error_clear);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dout_r <= 1'b0;
            dout_en_r <= 1'b0;
        end else if (tx_drive) begin
            dout_r <= tx_bit;
            dout_en_r <= 1'b1;
        end else if (tx_rise && tx_left_r == '0) begin
            dout_en_r <= 1'b0;
        end
    end

    assign serial_data_out = dout_r;
    assign serial_data_out_en = dout_en_r;
    assign rx_data_reg = rx_data_reg_r;
    assign rx_ready_flag = rx_ready_r;
    assign rx_sync_error = rx_err_r;
    assign tx_ready_flag = tx_ready_r;
    assign tx_sync_error = tx_err_r;

    // Checks.
    a_rx_sync_once: assert property (
        @(posedge core_clk) disable iff (reset)
        rx_fall && rx_fs_prev_r |-> !rx_sync)
        else $error("held receive sync counted twice");
    a_rx_dly0_start: assert property (
        @(posedge core_clk) disable iff (reset)
        rx_take && rx_data_delay == 2'h0 |=> rx_left_r == $past(rx_fbits) - 13'h1)
        else $error("zero delay receive did not start at sync");
    a_rx_buf_copy: assert property (
        @(posedge core_clk) disable iff (reset)
        rx_rise && rx_done_r && !rx_buf_full_r |=>
        rx_buf_full_r && rx_buffer_reg_r == $past(rx_shift_reg_r))
        else $error("shift to buffer copy missing");
    a_rx_ready_fall: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(rx_ready_r) |-> $past(rx_fall) && $past(rx_rdy_pend_r))
        else $error("receive ready set off a falling edge");
    a_rx_read_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        clk_en && rx_read && !(rx_fall && rx_rdy_pend_r) |=> !rx_ready_r)
        else $error("read did not clear receive ready");
    a_rx_sync_abort: assert property (
        @(posedge core_clk) disable iff (reset)
        rx_abort && rx_data_delay != 2'h0 |=> rx_err_r && rx_left_r == 13'h0)
        else $error("unexpected receive sync not handled");
    a_rx_ignore_keep: assert property (
        @(posedge core_clk) disable iff (reset)
        rx_unexp && rx_sync_ignore |=> rx_left_r == $past(rx_left_r) - 13'h1)
        else $error("ignored receive sync disturbed reception");
    a_tx_ready_fall: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(tx_ready_r) |-> $past(tx_fall) && $past(tx_rdy_pend_r))
        else $error("transmit ready set off a falling edge");
    a_tx_write_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        clk_en && tx_write && !(tx_fall && tx_rdy_pend_r) |=>
        !tx_ready_r && tx_data_reg_r == $past(tx_write_data))
        else $error("write did not clear transmit ready");
    a_tx_sync_abort: assert property (
        @(posedge core_clk) disable iff (reset)
        tx_abort && tx_data_delay != 2'h0 |=> tx_err_r && tx_restart_r)
        else $error("unexpected transmit sync not handled");
    a_tx_dly0_launch: assert property (
        @(posedge core_clk) disable iff (reset)
        tx_start && tx_fall |-> tx_data_delay == 2'h0 ##1 serial_data_out_en)
        else $error("zero delay launch wrong");
    a_tx_ignore_keep: assert property (
        @(posedge core_clk) disable iff (reset)
        tx_unexp && tx_sync_ignore |=> tx_left_r == $past(tx_left_r))
        else $error("ignored transmit sync disturbed element");
endmodule
`default_nettype wire

// ==== bench/fsp_codec_model.sv ====
// Behavioural far-end codec that drives bit clocks, syncs and data.
`timescale 1ns/1ps
`default_nettype none
module fsp_codec_model (
    // Receive pins
    output var logic rx_bit_clock,
    output var logic rx_frame_sync,
    output var logic serial_data_in,
    // Transmit pins
    output var logic tx_bit_clock,
    output var logic tx_frame_sync,
    input wire logic serial_data_out
);
    logic [63:0] cap;

    initial begin
        {rx_bit_clock, rx_frame_sync, serial_data_in} = 3'h0;
        {tx_bit_clock, tx_frame_sync} = 2'h0;
        cap = 64'h0;
    end

    // Clocks run only inside a burst and stand low between bursts.
    // Output is sampled half way into the high phase of the next bit.
    // The core launches late after a filtered edge, so this is the
    // only point that holds the bit for every data delay setting.
    task automatic burst(input int n, input logic [63:0] rfs,
                         input logic [63:0] tfs, input logic [63:0] din);
        for (int i = 0; i < n; i++) begin
            rx_bit_clock = 1'b1;
            tx_bit_clock = 1'b1;
            rx_frame_sync = rfs[i];
            tx_frame_sync = tfs[i];
            serial_data_in = din[i];
            #50;
            cap = {cap[62:0], serial_data_out};
            #50;
            rx_bit_clock = 1'b0;
            tx_bit_clock = 1'b0;
            #100;
        end
        rx_frame_sync = 1'b0;
        tx_frame_sync = 1'b0;
        // A released data line shows the inverse of its last value.
        serial_data_in = ~serial_data_in;
    endtask
endmodule
`default_nettype wire

// ==== bench/fsp_core_tb.sv ====
// Self-checking bench for the framed serial port core.
`timescale 1ns/1ps
`default_nettype none
module fsp_core_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic rx_bit_clock, rx_frame_sync, serial_data_in;
    logic tx_bit_clock, tx_frame_sync, serial_data_out, serial_data_out_en;
    logic [fsp_pkg::DLY_W-1:0] rx_data_delay = fsp_pkg::DLY_ONE;
    logic [fsp_pkg::DLY_W-1:0] tx_data_delay = fsp_pkg::DLY_ONE;
    logic rx_sync_ignore = 1'b0;
    logic tx_sync_ignore = 1'b0;
    logic [fsp_pkg::WLEN_W-1:0] rx_word_len = 6'h08;
    logic [fsp_pkg::WLEN_W-1:0] tx_word_len = 6'h08;
    logic [fsp_pkg::ECNT_W-1:0] elem_cnt = 7'h00;
    logic rx_read = 1'b0;
    logic rx_error_set = 1'b0;
    logic rx_error_clear = 1'b0;
    logic tx_write = 1'b0;
    logic tx_error_clear = 1'b0;
    logic [31:0] tx_write_data = 32'h0;
    logic [31:0] rx_data_reg;
    logic rx_ready_flag, rx_sync_error, tx_ready_flag, tx_sync_error;
    int miscompares = 0;
    int cmp_count = 0;

    always #12.5 core_clk = ~core_clk;

    fsp_codec_model u_model (.rx_bit_clock, .rx_frame_sync,
        .serial_data_in, .tx_bit_clock, .tx_frame_sync, .serial_data_out);

    fsp_core #(.DW(32)) u_dut (.core_clk, .reset, .clk_en(1'b1),
        .rx_bit_clock, .rx_frame_sync, .serial_data_in, .tx_bit_clock,
        .tx_frame_sync, .serial_data_out, .serial_data_out_en,
        .rx_data_delay, .rx_sync_ignore, .rx_word_len,
        .rx_phase1_element_count(elem_cnt), .tx_data_delay,
        .tx_sync_ignore, .tx_word_len, .tx_phase1_element_count(elem_cnt),
        .rx_read, .rx_data_reg, .rx_ready_flag, .rx_sync_error,
        .rx_error_set, .rx_error_clear, .tx_write, .tx_write_data,
        .tx_ready_flag, .tx_sync_error, .tx_error_set(1'b0),
        .tx_error_clear);

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle strobe; returns once the flag answer has landed.
    task automatic strobe(input int k);
        @(posedge core_clk);
        case (k)
            0: rx_read <= 1'b1;
            1: rx_error_clear <= 1'b1;
            2: rx_error_set <= 1'b1;
            default: tx_error_clear <= 1'b1;
        endcase
        @(posedge core_clk);
        {rx_read, rx_error_clear, rx_error_set, tx_error_clear} <= 4'h0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic wait_high(input logic tx);
        int n;
        n = 0;
        while ((tx ? tx_ready_flag : rx_ready_flag) !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        if ((tx ? tx_ready_flag : rx_ready_flag) !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    // Places a word MSB first at bit positions at .. at+w-1 of a burst.
    function automatic logic [63:0] place(input int at, input int w,
                                          input logic [31:0] v);
        logic [63:0] r;
        r = 64'h0;
        for (int k = 0; k < w; k++) r[at+k] = v[w-1-k];
        return r;
    endfunction

    task automatic rx_case(input logic ign, input logic [5:0] wl,
            input logic [63:0] fs, input int at, input int n,
            input logic [31:0] v, input logic err);
        @(posedge core_clk);
        rx_sync_ignore <= ign;
        rx_word_len <= wl;
        u_model.burst(n, fs, 64'h0, place(at, 32'(wl), v));
        wait_high(1'b0);
        check(rx_data_reg, v);
        check(32'(rx_sync_error), 32'(err));
        strobe(0);
        check(32'(rx_ready_flag), 32'h0);
        strobe(1);
    endtask

    task automatic tx_case(input logic ign, input logic [1:0] dly,
            input logic [63:0] fs, input int n, input logic [7:0] v,
            input logic err);
        @(posedge core_clk);
        tx_sync_ignore <= ign;
        tx_data_delay <= dly;
        tx_write_data <= 32'(v);
        tx_write <= 1'b1;
        @(posedge core_clk);
        tx_write <= 1'b0;
        @(posedge core_clk);
        #1;
        check(32'(tx_ready_flag), 32'h0);
        u_model.burst(n, 64'h0, fs, 64'h0);
        check(32'(u_model.cap[7:0]), 32'(v));
        check(32'(tx_sync_error), 32'(err));
        wait_high(1'b1);
        strobe(3);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        check(32'(rx_ready_flag), 32'(fsp_pkg::RX_READY_RST));
        check(32'(tx_ready_flag), 32'(fsp_pkg::TX_READY_RST));
        check(32'(serial_data_out_en), 32'h0);
        rx_case(1'b0, 6'h08, 64'h0f, 1, 10, 32'ha5, 1'b0);
        rx_case(1'b0, 6'h08, 64'h11, 5, 14, 32'h5a, 1'b1);
        check(32'(rx_sync_error), 32'h0);
        strobe(2);
        check(32'(rx_sync_error), 32'h1);
        strobe(1);
        rx_case(1'b1, 6'h08, 64'h11, 1, 10, 32'hc3, 1'b0);
        rx_case(1'b1, 6'h20, 64'h01010101, 1, 34, 32'hc0ffee42,
            1'b0);
        // Zero delay samples the first bit on the sync's own falling edge.
        @(posedge core_clk);
        rx_data_delay <= fsp_pkg::DLY_ZERO;
        rx_case(1'b0, 6'h08, 64'h1, 0, 9, 32'h3e, 1'b0);
        tx_case(1'b0, fsp_pkg::DLY_ONE, 64'h1, 10, 8'h3c, 1'b0);
        tx_case(1'b0, fsp_pkg::DLY_ZERO, 64'h1, 9, 8'h81, 1'b0);
        tx_case(1'b0, fsp_pkg::DLY_ONE, 64'h11, 14, 8'h96, 1'b1);
        tx_case(1'b1, fsp_pkg::DLY_ONE, 64'h11, 10, 8'h69, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
